//--- src/gpc_cfg.svh
// gpio port block: register offsets, field positions, reset values and widths
// assumes an 8-bit i/o space addressed by a 6-bit location number
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

`define GPC_ADDR_W 6
`define GPC_DATA_W 8
`define GPC_G0_W 8
`define GPC_G1_W 4

// i/o locations
`define GPC_OFF_MASK0 6'h12
`define GPC_OFF_MASK1 6'h20
`define GPC_OFF_FLAG 6'h3a
`define GPC_OFF_IMSK 6'h3b
`define GPC_OFF_CTRL 6'h35
`define GPC_OFF_INB 6'h16
`define GPC_OFF_DIRB 6'h17
`define GPC_OFF_VALB 6'h18
`define GPC_OFF_INA 6'h19
`define GPC_OFF_DIRA 6'h1a
`define GPC_OFF_VALA 6'h1b

// flag and enable bit positions (same in both registers)
`define GPC_BIT_EXT 6
`define GPC_BIT_G1 5
`define GPC_BIT_G0 4
// control register fields
`define GPC_BIT_PUD 6
`define GPC_CTRL_WMASK 8'h7b
`define GPC_MASK1_WMASK 8'h0f

// external pin sense codes
`define GPC_SENSE_LOW 2'h0
`define GPC_SENSE_ANY 2'h1
`define GPC_SENSE_FALL 2'h2
`define GPC_SENSE_RISE 2'h3

`define GPC_RST_BYTE 8'h00

`endif

//--- src/gpc_pkg.sv
// gpio port block: the state type shared by the design
// assumes gpc_cfg.svh is on the include path
`include "gpc_cfg.svh"

package gpc_pkg;

	typedef struct packed {
		logic [`GPC_G0_W-1:0] val_a;
		logic [`GPC_G0_W-1:0] dir_a;
		logic [`GPC_G1_W-1:0] val_b;
		logic [`GPC_G1_W-1:0] dir_b;
		logic [`GPC_G0_W-1:0] a_s1;
		logic [`GPC_G0_W-1:0] a_s2;
		logic [`GPC_G0_W-1:0] a_s3;
		logic [`GPC_G0_W-1:0] in_a;
		logic [`GPC_G1_W-1:0] b_s1;
		logic [`GPC_G1_W-1:0] b_s2;
		logic [`GPC_G1_W-1:0] b_s3;
		logic [`GPC_G1_W-1:0] in_b;
		logic ext_s1;
		logic ext_s2;
		logic ext_s3;
		logic ext_in;
		logic [`GPC_DATA_W-1:0] mask0;
		logic [`GPC_DATA_W-1:0] mask1;
		logic [`GPC_DATA_W-1:0] ctrl;
		logic en_ext;
		logic en_g1;
		logic en_g0;
		logic flag_ext;
		logic flag_g1;
		logic flag_g0;
		logic [`GPC_DATA_W-1:0] rdata;
	} gpc_state_t;

endpackage

//--- src/gpc_port.sv
// gpio port block: two ports (8 and 4 pins), pin-change and external interrupt logic
// assumes the cpu core drives i/o space strobes on clk_sys and takes interrupt requests as levels
`timescale 1ns/1ns

module gpc_port
	import gpc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [`GPC_ADDR_W-1:0] io_addr,
	input wire logic [`GPC_DATA_W-1:0] io_wdata,
	input wire logic io_we,
	input wire logic io_re,
	input wire logic io_bit_set,
	input wire logic io_bit_clr,
	input wire logic [2:0] io_bit_idx,
	output logic [`GPC_DATA_W-1:0] io_rdata,
	input wire logic cpu_global_irq_en,
	input wire logic ext_irq_ack,
	input wire logic group0_irq_ack,
	input wire logic group1_irq_ack,
	output logic ext_irq_req,
	output logic group0_irq_req,
	output logic group1_irq_req,
	input wire logic [`GPC_G0_W-1:0] group0_pins_in,
	output logic [`GPC_G0_W-1:0] group0_pins_out,
	output logic [`GPC_G0_W-1:0] group0_pins_oe,
	output logic [`GPC_G0_W-1:0] group0_pins_pullup,
	input wire logic [`GPC_G1_W-1:0] group1_pins_in,
	output logic [`GPC_G1_W-1:0] group1_pins_out,
	output logic [`GPC_G1_W-1:0] group1_pins_oe,
	output logic [`GPC_G1_W-1:0] group1_pins_pullup,
	input wire logic ext_irq_pin
);

	gpc_state_t st;
	gpc_state_t next_st;

	logic [`GPC_DATA_W-1:0] rd_cur;
	logic [`GPC_DATA_W-1:0] bit_sel;
	logic [`GPC_DATA_W-1:0] wd;
	logic [`GPC_DATA_W-1:0] ones;
	logic [`GPC_G0_W-1:0] next_in_a;
	logic [`GPC_G1_W-1:0] next_in_b;
	logic next_ext_in;
	logic [`GPC_G0_W-1:0] rise_a;
	logic [`GPC_G0_W-1:0] fall_a;
	logic [`GPC_G1_W-1:0] rise_b;
	logic [`GPC_G1_W-1:0] fall_b;
	logic next_flag_ext;
	logic next_flag_g0;
	logic next_flag_g1;
	logic [`GPC_G0_W-1:0] chg_a;
	logic [`GPC_G1_W-1:0] chg_b;
	logic wr;
	logic ext_rise;
	logic ext_fall;
	logic ext_evt;
	logic level_mode;
	logic set_ext;
	logic set_g0;
	logic set_g1;
	logic clr_ext;
	logic clr_g0;
	logic clr_g1;
	logic wr_flag;

	// read mux over the current state; reserved bits come back as zero
	always_comb begin
		unique case (io_addr)
			`GPC_OFF_VALA: rd_cur = st.val_a;
			`GPC_OFF_DIRA: rd_cur = st.dir_a;
			`GPC_OFF_INA: rd_cur = st.in_a;
			`GPC_OFF_VALB: rd_cur = {4'h0, st.val_b};
			`GPC_OFF_DIRB: rd_cur = {4'h0, st.dir_b};
			`GPC_OFF_INB: rd_cur = {4'h0, st.in_b};
			`GPC_OFF_MASK0: rd_cur = st.mask0;
			`GPC_OFF_MASK1: rd_cur = st.mask1 & `GPC_MASK1_WMASK;
			`GPC_OFF_CTRL: rd_cur = st.ctrl;
			`GPC_OFF_IMSK: rd_cur = {1'b0, st.en_ext, st.en_g1, st.en_g0, 4'h0};
			`GPC_OFF_FLAG: rd_cur = {1'b0, st.flag_ext & ~level_mode, st.flag_g1, st.flag_g0, 4'h0};
			default: rd_cur = `GPC_RST_BYTE;
		endcase
	end

	// write data: full byte writes, or read-modify-write of one bit
	always_comb begin
		bit_sel = 8'h01 << io_bit_idx;
		ones = io_bit_set ? bit_sel : 8'h00;
		wr = io_we | io_bit_set | io_bit_clr;
		if (io_we) begin
			wd = io_wdata;
		end else if (io_addr == `GPC_OFF_INA || io_addr == `GPC_OFF_INB || io_addr == `GPC_OFF_FLAG) begin
			wd = ones; // toggle and write-one-clear locations see only the addressed bit
		end else if (io_bit_set) begin
			wd = rd_cur | bit_sel;
		end else begin
			wd = rd_cur & ~bit_sel;
		end
		wr_flag = wr && io_addr == `GPC_OFF_FLAG;
	end

	// port a inputs: a bit moves once the second and third stages agree
	gpc_chg_det #(
		.W(`GPC_G0_W)
	) u_det_a (
		.mid(st.a_s2),
		.last(st.a_s3),
		.held(st.in_a),
		.next_held(next_in_a),
		.rise(rise_a),
		.fall(fall_a)
	);

	// port b inputs, same filter at the narrower width
	gpc_chg_det #(
		.W(`GPC_G1_W)
	) u_det_b (
		.mid(st.b_s2),
		.last(st.b_s3),
		.held(st.in_b),
		.next_held(next_in_b),
		.rise(rise_b),
		.fall(fall_b)
	);

	// external pin: one bit through the same filter, edges taken against its held value
	gpc_chg_det #(
		.W(1)
	) u_det_ext (
		.mid(st.ext_s2),
		.last(st.ext_s3),
		.held(st.ext_in),
		.next_held(next_ext_in),
		.rise(ext_rise),
		.fall(ext_fall)
	);

	// changes for the group flags, and the sense decode of the external pin
	always_comb begin
		chg_a = rise_a | fall_a;
		chg_b = rise_b | fall_b;
		level_mode = st.ctrl[1:0] == `GPC_SENSE_LOW;
		unique case (st.ctrl[1:0])
			`GPC_SENSE_ANY: ext_evt = ext_rise | ext_fall;
			`GPC_SENSE_FALL: ext_evt = ext_fall;
			`GPC_SENSE_RISE: ext_evt = ext_rise;
			default: ext_evt = 1'b0;
		endcase
	end

	// flag set and clear terms; a set in the clearing cycle wins
	always_comb begin
		set_ext = ext_evt;
		set_g0 = |(chg_a & st.mask0);
		set_g1 = |(chg_b & st.mask1[`GPC_G1_W-1:0]);
		clr_ext = ext_irq_ack | (wr_flag & wd[`GPC_BIT_EXT]);
		clr_g0 = group0_irq_ack | (wr_flag & wd[`GPC_BIT_G0]);
		clr_g1 = group1_irq_ack | (wr_flag & wd[`GPC_BIT_G1]);
	end

	// one flag cell per request source, so all three share the set-wins behaviour
	gpc_flag_cell u_flag_ext (
		.cur(st.flag_ext),
		.set(set_ext),
		.clr(clr_ext),
		.nxt(next_flag_ext)
	);
	gpc_flag_cell u_flag_g0 (
		.cur(st.flag_g0),
		.set(set_g0),
		.clr(clr_g0),
		.nxt(next_flag_g0)
	);
	gpc_flag_cell u_flag_g1 (
		.cur(st.flag_g1),
		.set(set_g1),
		.clr(clr_g1),
		.nxt(next_flag_g1)
	);

	// next state
	always_comb begin
		next_st = st;
		next_st.a_s1 = group0_pins_in;
		next_st.a_s2 = st.a_s1;
		next_st.a_s3 = st.a_s2;
		next_st.in_a = next_in_a;
		next_st.b_s1 = group1_pins_in;
		next_st.b_s2 = st.b_s1;
		next_st.b_s3 = st.b_s2;
		next_st.in_b = next_in_b;
		next_st.ext_s1 = ext_irq_pin;
		next_st.ext_s2 = st.ext_s1;
		next_st.ext_s3 = st.ext_s2;
		next_st.ext_in = next_ext_in;
		if (wr) begin
			unique case (io_addr)
				`GPC_OFF_VALA: next_st.val_a = wd;
				`GPC_OFF_DIRA: next_st.dir_a = wd;
				`GPC_OFF_INA: next_st.val_a = st.val_a ^ wd;
				`GPC_OFF_VALB: next_st.val_b = wd[`GPC_G1_W-1:0];
				`GPC_OFF_DIRB: next_st.dir_b = wd[`GPC_G1_W-1:0];
				`GPC_OFF_INB: next_st.val_b = st.val_b ^ wd[`GPC_G1_W-1:0];
				`GPC_OFF_MASK0: next_st.mask0 = wd;
				`GPC_OFF_MASK1: next_st.mask1 = wd & `GPC_MASK1_WMASK;
				`GPC_OFF_CTRL: next_st.ctrl = wd & `GPC_CTRL_WMASK;
				`GPC_OFF_IMSK: begin
					next_st.en_ext = wd[`GPC_BIT_EXT];
					next_st.en_g1 = wd[`GPC_BIT_G1];
					next_st.en_g0 = wd[`GPC_BIT_G0];
				end
				default: ;
			endcase
		end
		next_st.flag_ext = next_flag_ext;
		next_st.flag_g0 = next_flag_g0;
		next_st.flag_g1 = next_flag_g1;
		if (io_re) begin
			next_st.rdata = rd_cur;
		end
	end

	// all state registers; reset clears direction so pins float without a clock
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// read data comes from the register of the previous read strobe
	assign io_rdata = st.rdata;

	// requests: flag held and both enables set; level mode follows the pin low
	assign ext_irq_req = cpu_global_irq_en & st.en_ext & (level_mode ? ~st.ext_in : st.flag_ext);
	assign group0_irq_req = cpu_global_irq_en & st.en_g0 & st.flag_g0;
	assign group1_irq_req = cpu_global_irq_en & st.en_g1 & st.flag_g1;

	// pin drivers, each pin from its own bits and the global pull-up disable only
	gpc_pin_drv #(
		.W(`GPC_G0_W)
	) u_drv_a (
		.dir(st.dir_a),
		.val(st.val_a),
		.global_pullup_disable(st.ctrl[`GPC_BIT_PUD]),
		.oe(group0_pins_oe),
		.out(group0_pins_out),
		.pu_on(group0_pins_pullup)
	);

	gpc_pin_drv #(
		.W(`GPC_G1_W)
	) u_drv_b (
		.dir(st.dir_b),
		.val(st.val_b),
		.global_pullup_disable(st.ctrl[`GPC_BIT_PUD]),
		.oe(group1_pins_oe),
		.out(group1_pins_out),
		.pu_on(group1_pins_pullup)
	);

endmodule // gpc_port

// one synchronised input group: the held value moves only once the second and third stages agree
module gpc_chg_det
	import gpc_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic [W-1:0] mid,
	input wire logic [W-1:0] last,
	input wire logic [W-1:0] held,
	output logic [W-1:0] next_held,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);

	logic [W-1:0] agree;

	// two agreeing stages filter out a sample caught while the pin was moving
	always_comb begin
		agree = ~(mid ^ last);
		next_held = (last & agree) | (held & ~agree);
		rise = agree & last & ~held;
		fall = agree & ~last & held;
	end

endmodule // gpc_chg_det

// one interrupt flag: a set in the clearing cycle wins, so no event is lost
module gpc_flag_cell
	import gpc_pkg::*;
(
	input wire logic cur,
	input wire logic set,
	input wire logic clr,
	output logic nxt
);

	// hardware set beats routine entry and software write-one-clear
	assign nxt = set | (cur & ~clr);

endmodule // gpc_flag_cell

// one port's pin drivers: each pin follows its own direction and value bits and the global pull-up disable only
module gpc_pin_drv
	import gpc_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic [W-1:0] dir,
	input wire logic [W-1:0] val,
	input wire logic global_pullup_disable,
	output logic [W-1:0] oe,
	output logic [W-1:0] out,
	output logic [W-1:0] pu_on
);

	// direction one drives the value bit; the pull-up disable has no say here
	assign oe = dir;
	assign out = val;

	// pull-up only on an input whose value bit is one, never under the global disable
	assign pu_on = ~dir & val & {W{~global_pullup_disable}};

endmodule // gpc_pin_drv

//--- tb/gpc_port_chk.sv
// assertions on the gpio port block, seeing its ports only
// assumes it is bound into every gpc_port instance
`timescale 1ns/1ns
`include "gpc_cfg.svh"
module gpc_port_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [`GPC_ADDR_W-1:0] io_addr,
	input wire logic [`GPC_DATA_W-1:0] io_wdata,
	input wire logic io_we,
	input wire logic io_re,
	input wire logic io_bit_set,
	input wire logic io_bit_clr,
	input wire logic [2:0] io_bit_idx,
	input wire logic [`GPC_DATA_W-1:0] io_rdata,
	input wire logic cpu_global_irq_en,
	input wire logic group0_irq_req,
	input wire logic group1_irq_req,
	input wire logic [`GPC_G0_W-1:0] group0_pins_out,
	input wire logic [`GPC_G0_W-1:0] group0_pins_oe,
	input wire logic [`GPC_G0_W-1:0] group0_pins_pullup,
	input wire logic [`GPC_G1_W-1:0] group1_pins_out,
	input wire logic [`GPC_G1_W-1:0] group1_pins_oe,
	input wire logic [`GPC_G1_W-1:0] group1_pins_pullup
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// a read of one location, answered on the next edge
	sequence s_rd(a);
		io_re && io_addr == a;
	endsequence
	a_flag_resv_zero: assert property (s_rd(`GPC_OFF_FLAG) |=> (io_rdata & 8'h8f) == 8'h00)
		else $error("flag reserved bits not zero");
	a_mask1_resv_zero: assert property (s_rd(`GPC_OFF_MASK1) |=> io_rdata[7:4] == 4'h0)
		else $error("group1 mask upper bits not zero");
	a_pull_input_only: assert property ((group0_pins_pullup & (group0_pins_oe | ~group0_pins_out)) == 8'h00)
		else $error("group0 pull-up on a driven or low pin");
	a_pull_g1_only: assert property ((group1_pins_pullup & (group1_pins_oe | ~group1_pins_out)) == 4'h0)
		else $error("group1 pull-up on a driven or low pin");
	a_g0_req_gated: assert property (group0_irq_req |-> cpu_global_irq_en)
		else $error("group0 request without global enable");
	a_g1_req_gated: assert property (group1_irq_req |-> cpu_global_irq_en)
		else $error("group1 request without global enable");
	a_bit_set_one: assert property (io_bit_set && io_addr == `GPC_OFF_VALA |=>
		group0_pins_out == ($past(group0_pins_out) | (8'h01 << $past(io_bit_idx)))) else $error("bit set wrong");
	a_input_toggle: assert property (io_we && io_addr == `GPC_OFF_INA |=>
		group0_pins_out == ($past(group0_pins_out) ^ $past(io_wdata))) else $error("toggle wrong");
	a_dir_hold: assert property (!(io_we || io_bit_set || io_bit_clr) |=> $stable(group0_pins_oe))
		else $error("direction changed without access");
	a_reset_float: assert property (disable iff (1'b0) !rst_n |-> group0_pins_oe == 8'h00 && group1_pins_oe == 4'h0)
		else $error("pins driven during reset");
endmodule // gpc_port_chk
bind gpc_port gpc_port_chk u_chk (.clk_sys, .rst_n, .io_addr, .io_wdata, .io_we, .io_re, .io_bit_set, .io_bit_clr,
	.io_bit_idx, .io_rdata, .cpu_global_irq_en, .group0_irq_req, .group1_irq_req, .group0_pins_out, .group0_pins_oe,
	.group0_pins_pullup, .group1_pins_out, .group1_pins_oe, .group1_pins_pullup);

//--- tb/gpc_pins_model.sv
// far-side circuitry: resolves each pin from design drive, outside drive and pull-up
// assumes oe high means the design drives the pin
`timescale 1ns/1ns
module gpc_pins_model #(parameter int W = 8) (
	input wire logic clk_sys,
	input wire logic [W-1:0] oe,
	input wire logic [W-1:0] out,
	input wire logic [W-1:0] pu_on,
	input wire logic [W-1:0] drv_en,
	input wire logic [W-1:0] drv_val,
	output logic [W-1:0] level
);
	logic ph = 1'b0;
	// floating lines change every cycle so nothing relies on a settled value
	always @(posedge clk_sys) ph <= ~ph;
	// design drive wins, then outside drive, then pull-up
	always_comb begin
		for (int i = 0; i < W; i++) begin
			level[i] = oe[i] ? out[i] : drv_en[i] ? drv_val[i] : (pu_on[i] | ph);
		end
	end
endmodule // gpc_pins_model

//--- tb/tb.sv
// self-checking bench for the gpio port block
// assumes the checker is bound and the pin model stands on both ports
`timescale 1ns/1ns
`include "gpc_cfg.svh"
module tb;
	logic clk_sys = 0, rst_n = 1, io_we = 0, io_re = 0, io_bit_set = 0, io_bit_clr = 0, re_d = 0;
	logic cpu_global_irq_en = 0, ext_irq_ack = 0, group0_irq_ack = 0, group1_irq_ack = 0, ext_irq_pin = 1;
	logic [5:0] io_addr = 0;
	logic [7:0] io_wdata = 0, io_rdata, r, e, d0_en = 0, d0_val = 0;
	logic [2:0] io_bit_idx = 0, i;
	logic ext_irq_req, group0_irq_req, group1_irq_req;
	logic [7:0] group0_pins_in, group0_pins_out, group0_pins_oe, group0_pins_pullup, q[$];
	logic [3:0] group1_pins_in, group1_pins_out, group1_pins_oe, group1_pins_pullup, d1_val = 0;
	int n_mismatch = 0, checks_done = 0;
	integer seed = 32'hf527;
	gpc_port dut (.clk_sys, .rst_n, .io_addr, .io_wdata, .io_we, .io_re, .io_bit_set, .io_bit_clr, .io_bit_idx,
		.io_rdata, .cpu_global_irq_en, .ext_irq_ack, .group0_irq_ack, .group1_irq_ack, .ext_irq_req, .group0_irq_req,
		.group1_irq_req, .group0_pins_in, .group0_pins_out, .group0_pins_oe, .group0_pins_pullup, .group1_pins_in,
		.group1_pins_out, .group1_pins_oe, .group1_pins_pullup, .ext_irq_pin);
	gpc_pins_model #(.W(8)) u_pa (.clk_sys, .oe(group0_pins_oe), .out(group0_pins_out), .pu_on(group0_pins_pullup),
		.drv_en(d0_en), .drv_val(d0_val), .level(group0_pins_in));
	gpc_pins_model #(.W(4)) u_pb (.clk_sys, .oe(group1_pins_oe), .out(group1_pins_out), .pu_on(group1_pins_pullup),
		.drv_en(4'hf), .drv_val(d1_val), .level(group1_pins_in));
	initial forever #5 clk_sys = ~clk_sys;
	task results;
		if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task cmp_rd(input logic [7:0] g, input logic [7:0] x);
		checks_done++;
		if (g !== x) begin
			n_mismatch++;
			$display("Error %0t read %h expected %h", $time, g, x);
		end
	endtask
	task cmp_pin(input logic [7:0] g, input logic [7:0] x);
		checks_done++;
		if (g !== x) begin
			n_mismatch++;
			$display("Error %0t pins %h expected %h", $time, g, x);
		end
	endtask
	task tk(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk_sys) {io_addr, io_wdata, io_we} = {a, d, 1'b1};
		@(negedge clk_sys) io_we = 0;
	endtask
	task rd(input logic [5:0] a, input logic [7:0] x);
		@(negedge clk_sys) {io_addr, io_re} = {a, 1'b1};
		q.push_back(x);
		@(negedge clk_sys) io_re = 0;
	endtask
	task bop(input logic s, input logic [5:0] a, input logic [2:0] b);
		@(negedge clk_sys) {io_addr, io_bit_idx, io_bit_set, io_bit_clr} = {a, b, s, !s};
		@(negedge clk_sys) {io_bit_set, io_bit_clr} = 2'b00;
	endtask
	// read data lands one edge after the read is taken
	always @(posedge clk_sys) begin
		if (re_d) cmp_rd(io_rdata, q.pop_front());
		re_d <= io_re;
	end
	initial begin
		#900000 n_mismatch++;
		$display("Error %0t run limit reached", $time);
		results;
	end
	// pin walks keep to safe intermediate states
	initial begin
		#1 rst_n = 0;
		tk(5);
		rst_n = 1;
		rd(`GPC_OFF_MASK0, 0);
		rd(`GPC_OFF_FLAG, 0);
		rd(6'h00, 0);
		wr(`GPC_OFF_VALA, 8'hff);
		tk(4);
		rd(`GPC_OFF_INA, 8'hff);
		wr(`GPC_OFF_CTRL, 8'h40);
		cmp_pin(group0_pins_pullup, 0);
		r = 8'($random(seed));
		wr(`GPC_OFF_DIRA, r);
		cmp_pin(group0_pins_oe, r);
		wr(`GPC_OFF_CTRL, 0);
		cmp_pin(group0_pins_pullup, ~r);
		e = 8'($random(seed));
		wr(`GPC_OFF_INA, e);
		rd(`GPC_OFF_VALA, ~e);
		wr(`GPC_OFF_DIRA, 8'hff);
		tk(4);
		rd(`GPC_OFF_INA, ~e);
		i = 3'($random(seed));
		bop(1, `GPC_OFF_VALA, i);
		rd(`GPC_OFF_VALA, ~e | (8'h01 << i));
		bop(0, `GPC_OFF_DIRA, i);
		rd(`GPC_OFF_DIRA, ~(8'h01 << i));
		bop(1, `GPC_OFF_INA, i);
		rd(`GPC_OFF_VALA, ~e & ~(8'h01 << i));
		wr(`GPC_OFF_VALB, 8'hff);
		wr(`GPC_OFF_DIRB, 8'hff);
		tk(4);
		rd(`GPC_OFF_INB, 8'h0f);
		wr(`GPC_OFF_MASK1, 8'hff);
		rd(`GPC_OFF_MASK1, 8'h0f);
		// outside circuitry takes over port a, then pin changes
		{d0_en, d0_val} = 16'hff00;
		wr(`GPC_OFF_DIRA, 0);
		wr(`GPC_OFF_VALA, 0);
		wr(`GPC_OFF_MASK0, 8'h01);
		tk(5);
		wr(`GPC_OFF_FLAG, 8'hff);
		cpu_global_irq_en = 1;
		wr(`GPC_OFF_IMSK, 8'h70);
		d0_val = 8'h02;
		tk(5);
		rd(`GPC_OFF_FLAG, 0);
		d0_val = 8'h03;
		tk(5);
		cmp_pin(8'(group0_irq_req), 1);
		rd(`GPC_OFF_FLAG, 8'h10);
		group0_irq_ack = 1;
		tk(1);
		group0_irq_ack = 0;
		rd(`GPC_OFF_FLAG, 0);
		cpu_global_irq_en = 0;
		d0_val = 0;
		tk(5);
		cmp_pin(8'(group0_irq_req), 0);
		wr(`GPC_OFF_FLAG, 8'h10);
		rd(`GPC_OFF_FLAG, 0);
		wr(`GPC_OFF_DIRB, 0);
		tk(5);
		wr(`GPC_OFF_FLAG, 8'hff);
		cpu_global_irq_en = 1;
		d1_val = 4'h5;
		tk(5);
		cmp_pin(8'(group1_irq_req), 1);
		rd(`GPC_OFF_FLAG, 8'h20);
		group1_irq_ack = 1;
		tk(1);
		group1_irq_ack = 0;
		rd(`GPC_OFF_FLAG, 0);
		// every sense mode of the external pin, falling then rising
		for (int c = 0; c < 4; c++) begin
			wr(`GPC_OFF_CTRL, 8'(c));
			ext_irq_pin = 1;
			tk(5);
			wr(`GPC_OFF_FLAG, 8'h40);
			ext_irq_pin = 0;
			tk(5);
			cmp_pin(8'(ext_irq_req), 8'(c != 3));
			rd(`GPC_OFF_FLAG, (c == 1 || c == 2) ? 8'h40 : 8'h00);
			ext_irq_ack = 1;
			tk(1);
			ext_irq_ack = 0;
			ext_irq_pin = 1;
			tk(5);
			rd(`GPC_OFF_FLAG, (c == 1 || c == 3) ? 8'h40 : 8'h00);
		end
		tk(1);
		rst_n = 0;
		#1 cmp_pin(group0_pins_oe | 8'(group1_pins_oe), 0);
		tk(2);
		rst_n = 1;
		rd(`GPC_OFF_VALA, 0);
		tk(2);
		results;
	end
endmodule // tb
